// file: pkg/blk_tx_pkg.sv
// package: constants for the sample block transmitter
// assumes core_clk at 100 MHz and a separate strobe-domain link clock
package blk_tx_pkg;
  localparam int          CORE_CLK_MHZ     = 100;
  localparam int          WORDS_PER_BLOCK  = 8;
  localparam logic [2:0]  LAST_WORD_IDX    = 3'h7;
  localparam logic [31:0] HEADER_OFF       = 32'h1234_5678;
  localparam logic [31:0] HEADER_ON        = 32'h8765_4321;
  localparam logic [31:0] SPARE_WORD       = 32'h0000_0000;
  localparam int          SUSPEND_MAX_STB  = 16;
  localparam int          RESUME_MIN_STB   = 1;
  localparam int          PWR_RESET_MS     = 20;
  localparam int          PWR_RESET_CYC    = PWR_RESET_MS * 1000 * CORE_CLK_MHZ;
  localparam int          FIFO_DEPTH       = 8;
  localparam int          FIFO_WIDTH       = 33;
  localparam logic [1:0]  DRIVE_INPUT      = 2'h0;
  localparam logic [1:0]  DRIVE_ASYNC      = 2'h1;
  localparam logic [1:0]  DRIVE_SYNC       = 2'h2;
endpackage

// file: pkg/word_stream_if.sv
// interface: valid/ready word stream between transmitter modules
// assumes a single writer clock and a single reader clock
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if;
  logic        wrValid;
  logic        wrReady;
  logic [32:0] wrData;
  logic        rdValid;
  logic        rdReady;
  logic [32:0] rdData;
  modport fill (output wrValid, input wrReady, output wrData);
  modport drain (input rdValid, output rdReady, input rdData);
  modport fifo (input wrValid, output wrReady, input wrData, output rdValid, input rdReady, output rdData);
endinterface
`default_nettype wire

// file: verilog/async_word_fifo.sv
// module: dual-clock word FIFO with gray-coded pointers
// assumes DEPTH is a power of two
`timescale 1ns/1ps
`default_nettype none
module async_word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // write side
  input  wire logic wrClk,
  input  wire logic wrRst_n,
  // read side
  input  wire logic rdClk,
  input  wire logic rdRst_n,
  // stream
  word_stream_if.fifo st
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wBin_ff, nxt_wBin, wGray_ff, rBin_ff, nxt_rBin, rGray_ff;
  logic [AW:0] wGrayS1_ff, wGrayS2_ff, rGrayS1_ff, rGrayS2_ff;
  logic full, empty, doWr, doRd;

  assign full  = (wGray_ff == {~rGrayS2_ff[AW:AW-1], rGrayS2_ff[AW-2:0]});
  assign empty = (rGray_ff == wGrayS2_ff);
  assign st.wrReady = !full;
  assign doWr = st.wrValid && !full;
  assign doRd = st.rdReady && !empty;
  assign st.rdValid = !empty;
  assign st.rdData  = mem[rBin_ff[AW-1:0]];

  always_comb begin
    nxt_wBin = wBin_ff + (AW+1)'(doWr);
    nxt_rBin = rBin_ff + (AW+1)'(doRd);
  end

  always_ff @(posedge wrClk or negedge wrRst_n) begin
    if (!wrRst_n) begin
      wBin_ff <= '0; wGray_ff <= '0; rGrayS1_ff <= '0; rGrayS2_ff <= '0;
    end else begin
      wBin_ff <= nxt_wBin;
      wGray_ff <= nxt_wBin ^ (nxt_wBin >> 1);
      rGrayS1_ff <= rGray_ff;
      rGrayS2_ff <= rGrayS1_ff;
    end
  end

  always_ff @(posedge wrClk) begin
    if (doWr) begin
      mem[wBin_ff[AW-1:0]] <= st.wrData;
    end
  end

  always_ff @(posedge rdClk or negedge rdRst_n) begin
    if (!rdRst_n) begin
      rBin_ff <= '0; rGray_ff <= '0; wGrayS1_ff <= '0; wGrayS2_ff <= '0;
    end else begin
      rBin_ff <= nxt_rBin;
      rGray_ff <= nxt_rBin ^ (nxt_rBin >> 1);
      wGrayS1_ff <= wGray_ff;
      wGrayS2_ff <= wGrayS1_ff;
    end
  end
endmodule // async_word_fifo
`default_nettype wire

// file: verilog/sample_block_tx.sv
// module: jumper-configured sample block transmitter onto a front-panel data bus
// assumes link clock (strobe domain) from outside; jumpers pulled high when absent
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - after suspend asserts, data valid goes high within 16 strobe periods
// - after suspend clears, wait at least one strobe before valid again
// - data valid is active low, low only while a real word is presented
// - block count mode: off clears by module reset only, on also by timestamp reset
// - source select off takes bus lines, on takes front-panel inputs
// - marker suppress 1 gives no sync; 0 asserts sync on the eighth word
// - header pattern select picks one of two fixed header words
// - sample line: async output, strobe-registered output, or undriven input
// - reset line: same three drive modes as the sample line
// - internal reset high for 20 ms after power-up or reset button
// - sample rising edge while idle increments block counter then starts one block
// - reset pulse rising edge clears timestamp, and block counter if enabled
// - absent jumper reads one, fitted jumper reads zero
module sample_block_tx #(
  parameter int PWR_RESET_CYCLES = blk_tx_pkg::PWR_RESET_CYC
) (
  // clocks and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        linkClk,
  input  wire logic        resetButton_n,
  // jumpers, high when absent
  input  wire logic [1:0]  sample_line_drive_select,
  input  wire logic [1:0]  reset_line_drive_select,
  input  wire logic        block_count_reset_mode,
  input  wire logic        trigger_source_select,
  input  wire logic        frame_marker_suppress,
  input  wire logic        header_pattern_select,
  // front-panel triggers and timestamp clock tick
  input  wire logic        panelSample,
  input  wire logic        panelReset,
  input  wire logic        timestampTick,
  // bus lines, two-way
  input  wire logic        sampleLineIn,
  output logic             sampleLineOut,
  output logic             sampleLineOe_n,
  input  wire logic        resetLineIn,
  output logic             resetLineOut,
  output logic             resetLineOe_n,
  // data bus
  input  wire logic        suspend_n,
  output logic [31:0]      busData,
  output logic             dataValid_n,
  output logic             frameSync_n,
  // status
  output logic             internalReset,
  output logic [31:0]      blockCount,
  output logic [47:0]      timestamp
);
  typedef enum {IDLE, SEND} tx_state_t;
  typedef enum {RUN, HELD, RESUME} flow_state_t;

  logic [1:0] ps1_ff, ps2_ff, pr1_ff, pr2_ff, bs1_ff, bs2_ff, tt1_ff, tt2_ff;
  logic [3:0] cfg1_ff, cfg2_ff;
  logic selSmpPrev_ff, selRstPrev_ff, tickPrev_ff;
  logic [31:0] pwrCnt_ff, nxt_pwrCnt;
  logic btnPrev_ff;
  logic [31:0] blockCount_ff, nxt_blockCount;
  logic [47:0] timestamp_ff, nxt_timestamp;
  tx_state_t txState_ff, nxt_txState;
  logic [2:0] wordIdx_ff, nxt_wordIdx;
  logic [31:0] blockSnap_ff, nxt_blockSnap;
  logic [47:0] stampSnap_ff, nxt_stampSnap;
  logic hdrSel_ff, nxt_hdrSel, syncOff_ff, nxt_syncOff;
  logic selSample, selReset, smpRise, rstRise, tickRise, core_rst_n;
  logic [31:0] wordVal;

  // ============================================================
  // input synchronisers, core domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ps1_ff <= '0; ps2_ff <= '0; pr1_ff <= '0; pr2_ff <= '0;
      bs1_ff <= '0; bs2_ff <= '0; tt1_ff <= '0; tt2_ff <= '0;
      selSmpPrev_ff <= 1'b0; selRstPrev_ff <= 1'b0; tickPrev_ff <= 1'b0; btnPrev_ff <= 1'b0;
      cfg1_ff <= 4'hf;
      cfg2_ff <= 4'hf;
    end else begin
      ps1_ff <= {sampleLineIn, panelSample};
      ps2_ff <= ps1_ff;
      pr1_ff <= {resetLineIn, panelReset};
      pr2_ff <= pr1_ff;
      bs1_ff <= {resetButton_n, 1'b0};
      bs2_ff <= bs1_ff;
      tt1_ff <= {timestampTick, 1'b0};
      tt2_ff <= tt1_ff;
      selSmpPrev_ff <= selSample;
      selRstPrev_ff <= selReset;
      tickPrev_ff <= tt2_ff[1];
      btnPrev_ff <= bs2_ff[1];
      // the four mode jumpers pass two flops so a block never sees a half-made change
      cfg1_ff <= {block_count_reset_mode, trigger_source_select, frame_marker_suppress, header_pattern_select};
      cfg2_ff <= cfg1_ff;
    end
  end

  assign selSample = cfg2_ff[2] ? ps2_ff[0] : ps2_ff[1];
  assign selReset  = cfg2_ff[2] ? pr2_ff[0] : pr2_ff[1];
  assign smpRise  = selSample && !selSmpPrev_ff;
  assign rstRise  = selReset && !selRstPrev_ff;
  assign tickRise = tt2_ff[1] && !tickPrev_ff;

  // ============================================================
  // internal reset stretch
  always_comb begin
    nxt_pwrCnt = pwrCnt_ff;
    if (!bs2_ff[1] && btnPrev_ff) begin
      nxt_pwrCnt = 32'h0000_0000;
    end else if (pwrCnt_ff < 32'(PWR_RESET_CYCLES)) begin
      nxt_pwrCnt = pwrCnt_ff + 32'h0000_0001;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrCnt_ff <= '0;
    end else begin
      pwrCnt_ff <= nxt_pwrCnt;
    end
  end
  assign internalReset = (pwrCnt_ff < 32'(PWR_RESET_CYCLES));
  assign core_rst_n = rst_n;

  // ============================================================
  // counters and block framer
  logic fifoReady;
  always_comb begin
    nxt_blockCount = blockCount_ff;
    nxt_timestamp  = timestamp_ff;
    nxt_txState    = txState_ff;
    nxt_wordIdx    = wordIdx_ff;
    nxt_blockSnap  = blockSnap_ff;
    nxt_stampSnap  = stampSnap_ff;
    nxt_hdrSel     = hdrSel_ff;
    nxt_syncOff    = syncOff_ff;
    if (tickRise && timestamp_ff != 48'hFFFF_FFFF_FFFF) begin
      nxt_timestamp = timestamp_ff + 48'h0000_0000_0001;
    end
    if (rstRise) begin
      nxt_timestamp = '0;
      if (cfg2_ff[3]) begin
        nxt_blockCount = '0;
      end
    end
    case (txState_ff)
      IDLE: begin
        if (smpRise) begin
          nxt_blockCount = nxt_blockCount + 32'h0000_0001;
          nxt_blockSnap  = nxt_blockCount;
          nxt_stampSnap  = timestamp_ff;
          nxt_hdrSel     = cfg2_ff[0];
          nxt_syncOff    = cfg2_ff[1];
          nxt_wordIdx    = '0;
          nxt_txState    = SEND;
        end
      end
      SEND: begin
        if (fifoReady) begin
          nxt_wordIdx = wordIdx_ff + 3'h1;
          if (wordIdx_ff == blk_tx_pkg::LAST_WORD_IDX) begin
            nxt_txState = IDLE;
          end
        end
      end
      default: nxt_txState = IDLE;
    endcase
    if (internalReset) begin
      nxt_blockCount = '0;
      nxt_timestamp  = '0;
      nxt_txState    = IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      blockCount_ff <= '0; timestamp_ff <= '0; txState_ff <= IDLE; wordIdx_ff <= '0;
      blockSnap_ff <= '0; stampSnap_ff <= '0; hdrSel_ff <= 1'b0; syncOff_ff <= 1'b1;
    end else begin
      blockCount_ff <= nxt_blockCount;
      timestamp_ff  <= nxt_timestamp;
      txState_ff    <= nxt_txState;
      wordIdx_ff    <= nxt_wordIdx;
      blockSnap_ff  <= nxt_blockSnap;
      stampSnap_ff  <= nxt_stampSnap;
      hdrSel_ff     <= nxt_hdrSel;
      syncOff_ff    <= nxt_syncOff;
    end
  end
  assign blockCount = blockCount_ff;
  assign timestamp  = timestamp_ff;

  always_comb begin
    case (wordIdx_ff)
      3'h0: wordVal = hdrSel_ff ? blk_tx_pkg::HEADER_ON : blk_tx_pkg::HEADER_OFF;
      3'h1: wordVal = stampSnap_ff[31:0];
      3'h2: wordVal = {16'h0000, stampSnap_ff[47:32]};
      3'h4: wordVal = blockSnap_ff;
      default: wordVal = blk_tx_pkg::SPARE_WORD;
    endcase
  end

  // ============================================================
  // clock-domain crossing FIFO
  word_stream_if st ();
  logic link_rst_n, lr1_ff;
  assign st.wrValid = (txState_ff == SEND);
  assign st.wrData  = {(wordIdx_ff == blk_tx_pkg::LAST_WORD_IDX) && !syncOff_ff, wordVal};
  assign fifoReady  = st.wrReady;

  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      lr1_ff <= 1'b0; link_rst_n <= 1'b0;
    end else begin
      lr1_ff <= 1'b1; link_rst_n <= lr1_ff;
    end
  end

  async_word_fifo #(.WIDTH(blk_tx_pkg::FIFO_WIDTH), .DEPTH(blk_tx_pkg::FIFO_DEPTH)) u_fifo (
    .wrClk   (core_clk),
    .wrRst_n (core_rst_n),
    .rdClk   (linkClk),
    .rdRst_n (link_rst_n),
    .st      (st.fifo)
  );

  // ============================================================
  // link domain: suspend flow control and bus outputs
  logic su1_ff, su2_ff;
  flow_state_t flow_ff, nxt_flow;
  logic [31:0] busData_ff, nxt_busData;
  logic valid_ff, nxt_valid, sync_ff, nxt_sync;
  logic [1:0] ls1_ff, ls2_ff;
  logic sampleReg_ff, resetReg_ff;

  always_comb begin
    nxt_flow = flow_ff;
    case (flow_ff)
      RUN:     if (!su2_ff) nxt_flow = HELD;
      HELD:    if (su2_ff) nxt_flow = RESUME;
      RESUME:  nxt_flow = su2_ff ? RUN : HELD;
      default: nxt_flow = RUN;
    endcase
  end
  assign st.rdReady = (flow_ff == RUN) && su2_ff;
  always_comb begin
    nxt_busData = busData_ff;
    nxt_valid   = 1'b0;
    nxt_sync    = 1'b0;
    if (st.rdReady && st.rdValid) begin
      nxt_busData = st.rdData[31:0];
      nxt_valid   = 1'b1;
      nxt_sync    = st.rdData[32];
    end
  end

  always_ff @(posedge linkClk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      su1_ff <= 1'b1; su2_ff <= 1'b1; flow_ff <= RUN; busData_ff <= '0;
      valid_ff <= 1'b0; sync_ff <= 1'b0; ls1_ff <= '0; ls2_ff <= '0;
      sampleReg_ff <= 1'b0; resetReg_ff <= 1'b0;
    end else begin
      su1_ff <= suspend_n;
      su2_ff <= su1_ff;
      flow_ff <= nxt_flow;
      busData_ff <= nxt_busData;
      valid_ff <= nxt_valid;
      sync_ff <= nxt_sync;
      ls1_ff <= {panelReset, panelSample};
      ls2_ff <= ls1_ff;
      sampleReg_ff <= ls2_ff[0];
      resetReg_ff  <= ls2_ff[1];
    end
  end
  assign busData     = busData_ff;
  assign dataValid_n = !valid_ff;
  assign frameSync_n = !sync_ff;

  // ============================================================
  // bus line drive; only drives when front panel is the source
  always_comb begin
    sampleLineOut  = 1'b0;
    sampleLineOe_n = 1'b1;
    case (sample_line_drive_select)
      blk_tx_pkg::DRIVE_ASYNC: begin sampleLineOut = panelSample; sampleLineOe_n = 1'b0; end
      blk_tx_pkg::DRIVE_SYNC:  begin sampleLineOut = sampleReg_ff; sampleLineOe_n = 1'b0; end
      default: sampleLineOe_n = 1'b1;
    endcase
    if (!trigger_source_select) sampleLineOe_n = 1'b1;
  end
  always_comb begin
    resetLineOut  = 1'b0;
    resetLineOe_n = 1'b1;
    case (reset_line_drive_select)
      blk_tx_pkg::DRIVE_ASYNC: begin resetLineOut = panelReset; resetLineOe_n = 1'b0; end
      blk_tx_pkg::DRIVE_SYNC:  begin resetLineOut = resetReg_ff; resetLineOe_n = 1'b0; end
      default: resetLineOe_n = 1'b1;
    endcase
    if (!trigger_source_select) resetLineOe_n = 1'b1;
  end
endmodule // sample_block_tx
`default_nettype wire

// file: verif/sample_block_tx_properties.sv
// checker: port properties of sample_block_tx
// assumes jumpers change only while no block is on the bus
`timescale 1ns/1ps
`default_nettype none
module sample_block_tx_properties (
  // clocks, reset, jumpers
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        linkClk,
  input wire logic [1:0]  sample_line_drive_select,
  input wire logic [1:0]  reset_line_drive_select,
  input wire logic        block_count_reset_mode,
  input wire logic        trigger_source_select,
  input wire logic        frame_marker_suppress,
  input wire logic        header_pattern_select,
  // watched signals
  input wire logic        panelReset,
  input wire logic        suspend_n,
  input wire logic        sampleLineOe_n,
  input wire logic        resetLineOe_n,
  input wire logic [31:0] busData,
  input wire logic        dataValid_n,
  input wire logic        frameSync_n,
  input wire logic [31:0] blockCount,
  input wire logic [47:0] timestamp
);
  // =====================================================
  // word position within a block
  logic [2:0] wordIdx_ff;
  logic       sDrive;
  logic       rDrive;
  // drive codes 1 and 2 are exactly the ones whose bits differ
  assign sDrive = trigger_source_select & ^sample_line_drive_select;
  assign rDrive = trigger_source_select & ^reset_line_drive_select;
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) wordIdx_ff <= 3'h0;
    else if (!dataValid_n) wordIdx_ff <= wordIdx_ff + 3'h1;
  end
  sequence lastWord;
    !dataValid_n && wordIdx_ff == 3'h7;
  endsequence
  sequence tsPulse;
    $rose(panelReset) && trigger_source_select;
  endsequence
  // =====================================================
  // link side
  a_suspend_stop: assert property (@(posedge linkClk) disable iff (!rst_n)
    $fell(suspend_n) |-> ##[0:16] dataValid_n) else $error("valid held under suspend");
  a_resume_gap: assert property (@(posedge linkClk) disable iff (!rst_n)
    $rose(suspend_n) && $past(dataValid_n) |-> dataValid_n) else $error("resumed too early");
  a_header_word: assert property (@(posedge linkClk) disable iff (!rst_n)
    !dataValid_n && wordIdx_ff == 3'h0 |->
    busData == (header_pattern_select ? blk_tx_pkg::HEADER_ON : blk_tx_pkg::HEADER_OFF)) else $error("bad header");
  a_count_word: assert property (@(posedge linkClk) disable iff (!rst_n)
    !dataValid_n && wordIdx_ff == 3'h4 |-> busData == blockCount) else $error("bad count word");
  a_sync_last: assert property (@(posedge linkClk) disable iff (!rst_n)
    lastWord |-> frameSync_n == frame_marker_suppress) else $error("bad sync on last word");
  a_sync_only: assert property (@(posedge linkClk) disable iff (!rst_n)
    !frameSync_n |-> !dataValid_n && wordIdx_ff == 3'h7) else $error("stray sync");
  // =====================================================
  // core side
  a_line_drive: assert property (@(posedge core_clk) disable iff (!rst_n)
    sampleLineOe_n == !sDrive && resetLineOe_n == !rDrive) else $error("bad line enable");
  a_ts_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    tsPulse |-> ##[1:6] timestamp == 48'h0000_0000_0000) else $error("timestamp not cleared");
  a_bc_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    tsPulse ##0 (!block_count_reset_mode && blockCount != 32'h0000_0000) |->
    ##1 (blockCount != 32'h0000_0000) [*6]) else $error("count cleared in keep mode");
endmodule // sample_block_tx_properties
bind sample_block_tx sample_block_tx_properties props (.*);
`default_nettype wire

// file: verif/fpdp_receiver_model.sv
// model: receiver at the far end of the data bus
// assumes linkClk is the bus strobe and stall comes from the bench
`timescale 1ns/1ps
`default_nettype none
module fpdp_receiver_model (
  // strobe and flow control
  input  wire logic        linkClk,
  input  wire logic        stall,
  // bus
  input  wire logic        dataValid_n,
  input  wire logic        frameSync_n,
  input  wire logic [31:0] busData,
  output var logic         suspend_n
);
  int          rxCount = 0;
  logic [31:0] rxWord [8];
  logic [7:0]  rxSync = 8'h00;
  initial suspend_n = 1'h1;
  // suspend only moves just after a strobe edge
  always @(posedge linkClk) begin
    suspend_n <= !stall;
    if (!dataValid_n) begin
      rxWord[rxCount % 8] <= busData;
      rxSync[rxCount % 8] <= !frameSync_n;
      rxCount <= rxCount + 1;
    end
  end
endmodule // fpdp_receiver_model
`default_nettype wire

// file: verif/sample_block_tx_bench.sv
// bench: drives sample_block_tx and checks blocks seen by the receiver model
// assumes the receiver model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module sample_block_tx_bench;
  typedef struct packed {
    logic        hdr, sup, src;
    logic [1:0]  drv;
    logic [31:0] head;
    logic        sync, oe_n;
  } row_t;
  // =====================================================
  // stimulus, observed signals, parts
  logic        core_clk = 1'h0, linkClk = 1'h0, rst_n = 1'h0, resetButton_n = 1'h1, stall = 1'h0;
  logic [1:0]  sample_line_drive_select = 2'h0, reset_line_drive_select = 2'h0;
  logic        block_count_reset_mode = 1'h0, trigger_source_select = 1'h1;
  logic        frame_marker_suppress = 1'h0, header_pattern_select = 1'h0;
  logic        panelSample = 1'h0, panelReset = 1'h0, timestampTick = 1'h0, extSample = 1'h0, extReset = 1'h0;
  logic        sampleLineOut, sampleLineOe_n, resetLineOut, resetLineOe_n;
  logic        suspend_n, dataValid_n, frameSync_n, internalReset;
  logic [31:0] busData, blockCount, bc = 32'h0000_0000;
  logic [47:0] timestamp;
  int          fail_count = 0, samples_checked = 0, words = 0, n;
  // bus lines read back the wire, whoever drives it
  wire         sampleLineIn = sampleLineOe_n ? extSample : sampleLineOut;
  wire         resetLineIn = resetLineOe_n ? extReset : resetLineOut;
  row_t        rows [4] = '{
    '{1'h0, 1'h0, 1'h1, 2'h1, blk_tx_pkg::HEADER_OFF, 1'h1, 1'h0},
    '{1'h1, 1'h1, 1'h1, 2'h2, blk_tx_pkg::HEADER_ON, 1'h0, 1'h0},
    '{1'h1, 1'h0, 1'h0, 2'h0, blk_tx_pkg::HEADER_ON, 1'h1, 1'h1},
    '{1'h0, 1'h1, 1'h1, 2'h3, blk_tx_pkg::HEADER_OFF, 1'h0, 1'h1}};
  always #5 core_clk = ~core_clk;
  always #62.5 linkClk = ~linkClk;
  sample_block_tx #(.PWR_RESET_CYCLES(20)) DUT (.*);
  fpdp_receiver_model receiver (.*);
  // =====================================================
  // tasks
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic pulse(ref logic s, input int w);
    s = 1'h1;
    tick(w);
    s = 1'h0;
    tick(w);
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // waits for the reset stretch to end, or for the receiver to hold target words
  task automatic waitFor(input logic idle, input int target);
    for (n = 0; n < 3000; n++) begin
      if (idle ? internalReset === 1'h0 : receiver.rxCount >= target) break;
      tick(1);
    end
    if (n == 3000) begin
      fail_count++;
      wrap_up();
    end
  endtask
  task automatic block(ref logic s);
    pulse(s, 3);
    bc++;
    words += 8;
    waitFor(1'h0, words);
  endtask
  task automatic chkBlock(input logic [31:0] head, input logic sync);
    chk(receiver.rxWord[0], head);
    chk(receiver.rxWord[3], 32'h0000_0000);
    chk(receiver.rxWord[4], bc);
    chk(receiver.rxSync, {sync, 7'h00});
  endtask
  // =====================================================
  // sequence
  initial begin
    tick(16);
    rst_n = 1'h1;
    tick(1);
    chk(internalReset, 1'h1);
    waitFor(1'h1, 0);
    chk(n >= 15 && n <= 25, 1'h1);
    foreach (rows[r]) begin
      header_pattern_select = rows[r].hdr;
      frame_marker_suppress = rows[r].sup;
      trigger_source_select = rows[r].src;
      sample_line_drive_select = rows[r].drv;
      reset_line_drive_select = rows[r].drv;
      tick(2);
      chk(sampleLineOe_n, rows[r].oe_n);
      chk(resetLineOe_n, rows[r].oe_n);
      if (rows[r].src) block(panelSample);
      else block(extSample);
      chkBlock(rows[r].head, rows[r].sync);
    end
    frame_marker_suppress = 1'h0;
    sample_line_drive_select = 2'h0;
    reset_line_drive_select = 2'h0;
    // second edge lands while the first block is being built
    pulse(panelSample, 2);
    block(panelSample);
    tick(200);
    chk(blockCount, bc);
    chk(receiver.rxCount, words);
    // suspend in mid-block, then resume
    pulse(panelSample, 3);
    bc++;
    words += 8;
    waitFor(1'h0, words - 6);
    stall = 1'h1;
    tick(300);
    chk(dataValid_n, 1'h1);
    chk(receiver.rxCount < words, 1'h1);
    stall = 1'h0;
    waitFor(1'h0, words);
    chkBlock(blk_tx_pkg::HEADER_OFF, 1'h1);
    // timestamp reset with the block count kept
    // reset line: strobe-registered drive lags the panel, direct drive does not
    reset_line_drive_select = blk_tx_pkg::DRIVE_SYNC;
    panelReset = 1'h1;
    tick(1);
    chk(resetLineOut, 1'h0);
    tick(60);
    chk(resetLineOut, 1'h1);
    reset_line_drive_select = blk_tx_pkg::DRIVE_ASYNC;
    panelReset = 1'h0;
    tick(1);
    chk(resetLineOut, 1'h0);
    reset_line_drive_select = 2'h0;
    tick(60);
    repeat (3) pulse(timestampTick, 3);
    pulse(panelReset, 3);
    chk(timestamp, 48'h0000_0000_0000);
    chk(blockCount, bc);
    // reset button restarts the stretch and clears the count
    // the button is active low: press, then let go
    resetButton_n = 1'h0;
    tick(3);
    resetButton_n = 1'h1;
    tick(3);
    chk(internalReset, 1'h1);
    waitFor(1'h1, 0);
    chk(blockCount, 32'h0000_0000);
    bc = 32'h0000_0000;
    block(panelSample);
    chkBlock(blk_tx_pkg::HEADER_OFF, 1'h1);
    // reset pulse from the bus line also clears the count
    trigger_source_select = 1'h0;
    block_count_reset_mode = 1'h1;
    tick(2);
    pulse(extReset, 3);
    chk(blockCount, 32'h0000_0000);
    wrap_up();
  end
endmodule // sample_block_tx_bench
`default_nettype wire
